/* File: src/igr_defs.vh */
// Constants for the interrupt group routing block: offsets, fields, reset values
`ifndef IGR_DEFS_VH
`define IGR_DEFS_VH

`define IGR_NORMAL_REQUEST_N 16
`define IGR_NLIST 4

`define IGR_OFF_DIST_CTRL 12'h000
`define IGR_OFF_CPU_CTRL 12'h004
`define IGR_OFF_GROUP 12'h008
`define IGR_OFF_SET_PEND 12'h00C
`define IGR_OFF_CLR_PEND 12'h010
`define IGR_OFF_ACTIVE 12'h014
`define IGR_OFF_PRIM_SPLIT 12'h018
`define IGR_OFF_ALIAS_SPLIT 12'h01C
`define IGR_OFF_PRIO_BASE 12'h020
`define IGR_OFF_PRIM_ACK 12'h030
`define IGR_OFF_ALIAS_ACK 12'h034
`define IGR_OFF_PRIM_END 12'h038
`define IGR_OFF_ALIAS_END 12'h03C
`define IGR_OFF_LIST_BASE 12'h040
`define IGR_OFF_STATUS 12'h050

`define IGR_D_G0 0
`define IGR_D_G1 1
`define IGR_C_G0 0
`define IGR_C_G1 1
`define IGR_C_SHARED_ACK 2
`define IGR_C_FAST 3
`define IGR_C_COMMON_SPLIT 4

`define IGR_LR_GRP 10
`define IGR_LR_PEND 11

`define IGR_RST_DIST_CTRL 2'h0
`define IGR_RST_CPU_CTRL 5'h00
`define IGR_RST_GROUP 16'h0000
`define IGR_RST_PRIM_SPLIT 3'h2
`define IGR_RST_ALIAS_SPLIT 3'h3
`define IGR_RST_LIST 12'h000
`define IGR_SPURIOUS 10'h3FF
`define IGR_IDLE_PRI 8'hFF

`endif

/* File: src/igr_hppi.v */
// Highest priority pending interrupt and running priority selector
`timescale 1ns/1ns
`default_nettype none
`include "igr_defs.vh"

module igr_hppi (
   input wire [15:0] eligible,
   input wire [15:0] active,
   input wire [127:0] pri_flat,
   output reg best_valid,
   output reg [3:0] best_id,
   output reg [7:0] best_pri,
   output reg [7:0] run_pri
);

   integer i;
   reg [7:0] p;

   // Lowest value wins; ties go to the lowest number
   always @* begin
      best_valid = 1'b0;
      best_id = 4'h0;
      best_pri = `IGR_IDLE_PRI;
      run_pri = `IGR_IDLE_PRI;
      p = 8'h00;
      for (i = 0; i < `IGR_NORMAL_REQUEST_N; i = i + 1) begin
         p = pri_flat[8*i +: 8];
         if (eligible[i] && (!best_valid || p < best_pri)) begin
            best_valid = 1'b1;
            best_id = i[3:0];
            best_pri = p;
         end
         if (active[i] && p < run_pri) begin
            run_pri = p;
         end
      end
   end

endmodule // igr_hppi
`default_nettype wire

/* File: src/igr_top.v */
// Interrupt group routing: distributor, CPU interface and virtual request outputs
//
// Behaviour
// R1 - On reset every interrupt sits in group 0.
// R2 - One group assignment bit per interrupt; a set bit means group 1.
// R3 - Fast routing on: pending group 0 interrupts drive the fast request.
// R4 - Fast routing on: group 1 interrupts drive the normal request.
// R5 - Distributor has independent group 0 and group 1 forwarding enables.
// R6 - CPU interface has independent group 0 and group 1 signalling enables.
// R7 - Shared ack off: group 0 via primary ack/end, group 1 via alias.
// R8 - Alias ack/end only in second version; older uses shared-ack mode; the older build here shares the ack only when the shared-ack bit is set.
// R9 - Common split off: primary split for group 0, alias split for group 1.
// R10 - Common split on: primary split point serves both groups.
// R11 - Without security option, group reset value is implementation defined.
// R12 - Virtual fast and normal requests follow each virtual interrupt's group.
// R13 - Managing software loads list registers to make a virtual interrupt pending.
// R14 - Processor taking a fast request masks fast and normal requests.
// R15 - Processor taking a normal request masks normal requests only.
// R16 - Group 0 with fast routing: fast request needs group 0 enable, else normal; the build here raises no request without that enable.
// R17 - Request outputs are registered levels re-evaluated every cycle.
`timescale 1ns/1ns
`default_nettype none
`include "igr_defs.vh"

module igr_top #(
   parameter VERSION2 = 1,
   parameter SECURITY = 1,
   parameter [15:0] GROUP_RESET = 16'h0000
) (
   input wire pclk,
   input wire presetn,
   input wire [11:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [15:0] irq_in,
   output reg fast_request_n,
   output reg normal_request_n,
   output reg virtual_fast_request,
   output reg virtual_normal_request
);

   // Group reset value is a constant either way
   localparam [15:0] GRP_RST = (SECURITY != 0) ? `IGR_RST_GROUP : GROUP_RESET; // R1 R11

   reg [1:0] dist_ctrl_r;
   reg [4:0] cpu_ctrl_r;
   reg [15:0] group_r;
   reg [15:0] pend_r;
   reg [15:0] pend_nxt;
   reg [15:0] act_r;
   reg [15:0] act_nxt;
   reg [15:0] irq_q_r;
   reg [2:0] prim_split_r;
   reg [2:0] alias_split_r;
   reg [7:0] pri_r [0:15];
   reg [11:0] list_r [0:3];
   reg ack_take_r;
   reg [3:0] ack_id_r;
   reg [31:0] rd_data;
   reg ack_hit;
   reg [127:0] pri_flat;
   reg [15:0] eligible;
   reg [7:0] split_msk;
   reg next_int;
   reg fast_nxt;
   reg normal_nxt;
   reg vfast_nxt;
   reg vnormal_nxt;
   reg [15:0] end_clr;
   reg [15:0] ack_set;
   integer i;
   integer j;
   integer k;

   wire best_valid;
   wire [3:0] best_id;
   wire [7:0] best_pri;
   wire [7:0] run_pri;
   wire [11:0] word_addr = {paddr[11:2], 2'b00};
   wire acc_first = psel & penable & ~pready;
   wire acc_done = psel & penable & pready;
   wire wr_en = acc_done & pwrite;
   wire rd_done = acc_done & ~pwrite;
   wire best_grp1 = group_r[best_id];
   wire shared_ack = cpu_ctrl_r[`IGR_C_SHARED_ACK];
   wire alias_on = (VERSION2 != 0);

   // Priority mask for one split point; the alias form keeps one more bit
   function [7:0] split_mask;
      input [2:0] bp;
      input alias_form;
      begin
         if (alias_form) begin
            split_mask = 8'hFF << bp;
         end else begin
            split_mask = 8'hFF << ({1'b0, bp} + 4'h1);
         end
      end
   endfunction

   function [31:0] ack_word;
      input ok;
      input [3:0] id;
      begin
         ack_word = ok ? {28'h0000000, id} : {22'h000000, `IGR_SPURIOUS};
      end
   endfunction

   always @* begin
      for (i = 0; i < `IGR_NORMAL_REQUEST_N; i = i + 1) begin
         pri_flat[8*i +: 8] = pri_r[i];
         eligible[i] = pend_r[i] & ~act_r[i] &
            (group_r[i] ? dist_ctrl_r[`IGR_D_G1] : dist_ctrl_r[`IGR_D_G0]); // R2 R5
      end
   end

   igr_hppi u_hppi (
      .eligible(eligible),
      .active(act_r),
      .pri_flat(pri_flat),
      .best_valid(best_valid),
      .best_id(best_id),
      .best_pri(best_pri),
      .run_pri(run_pri)
   );

   // Preemption check against the running priority, masked by the group's split point
   always @* begin
      if (!best_grp1) begin
         split_msk = split_mask(prim_split_r, 1'b0); // R9
      end else if (cpu_ctrl_r[`IGR_C_COMMON_SPLIT]) begin
         split_msk = split_mask(prim_split_r, 1'b0); // R10
      end else begin
         split_msk = split_mask(alias_split_r, 1'b1); // R9
      end
      next_int = best_valid && ((act_r == 16'h0000) || (best_pri < (run_pri & split_msk)));
   end

   // Request routing to the processor
   always @* begin
      fast_nxt = 1'b1;
      normal_nxt = 1'b1;
      if (next_int) begin
         if (!best_grp1 && cpu_ctrl_r[`IGR_C_FAST]) begin
            if (cpu_ctrl_r[`IGR_C_G0]) begin
               fast_nxt = 1'b0; // R3 R16
            end
         end else if ((!best_grp1 && cpu_ctrl_r[`IGR_C_G0]) ||
                      (best_grp1 && cpu_ctrl_r[`IGR_C_G1])) begin
            normal_nxt = 1'b0; // R4 R6 R16
         end
      end
   end

   // Virtual requests from pending list entries
   always @* begin
      vfast_nxt = 1'b0;
      vnormal_nxt = 1'b0;
      for (j = 0; j < `IGR_NLIST; j = j + 1) begin
         if (list_r[j][`IGR_LR_PEND]) begin
            if (list_r[j][`IGR_LR_GRP]) begin
               vnormal_nxt = 1'b1; // R12
            end else begin
               vfast_nxt = 1'b1; // R12
            end
         end
      end
   end

   // Read data and acknowledge selection
   always @* begin
      rd_data = 32'h00000000;
      ack_hit = 1'b0;
      case (word_addr)
         `IGR_OFF_DIST_CTRL: begin
            rd_data = {30'h00000000, dist_ctrl_r};
         end
         `IGR_OFF_CPU_CTRL: begin
            rd_data = {27'h0000000, cpu_ctrl_r};
         end
         `IGR_OFF_GROUP: begin
            rd_data = {16'h0000, group_r};
         end
         `IGR_OFF_SET_PEND, `IGR_OFF_CLR_PEND: begin
            rd_data = {16'h0000, pend_r};
         end
         `IGR_OFF_ACTIVE: begin
            rd_data = {16'h0000, act_r};
         end
         `IGR_OFF_PRIM_SPLIT: begin
            rd_data = {29'h00000000, prim_split_r};
         end
         `IGR_OFF_ALIAS_SPLIT: begin
            rd_data = {29'h00000000, alias_split_r};
         end
         `IGR_OFF_PRIM_ACK: begin
            ack_hit = next_int && (shared_ack || !best_grp1); // R7 R8
            rd_data = ack_word(ack_hit, best_id);
         end
         `IGR_OFF_ALIAS_ACK: begin
            if (alias_on) begin
               ack_hit = next_int && !shared_ack && best_grp1; // R7 R8
               rd_data = ack_word(ack_hit, best_id);
            end
         end
         `IGR_OFF_STATUS: begin
            rd_data = {run_pri, best_pri, 6'h00, virtual_normal_request, virtual_fast_request,
                       ~normal_request_n, ~fast_request_n, next_int, best_grp1, best_id};
         end
         default: begin
            if (word_addr[11:4] == `IGR_OFF_PRIO_BASE >> 4) begin
               rd_data = {pri_r[{word_addr[3:2], 2'd3}], pri_r[{word_addr[3:2], 2'd2}],
                          pri_r[{word_addr[3:2], 2'd1}], pri_r[{word_addr[3:2], 2'd0}]};
            end else if (word_addr[11:4] == `IGR_OFF_LIST_BASE >> 4) begin
               rd_data = {20'h00000, list_r[word_addr[3:2]]};
            end
         end
      endcase
   end

   // Pending and active updates; a new event wins over a clear in the same cycle
   always @* begin
      end_clr = 16'h0000;
      ack_set = 16'h0000;
      pend_nxt = pend_r;
      if (rd_done && ack_take_r) begin
         ack_set[ack_id_r] = 1'b1;
         pend_nxt[ack_id_r] = 1'b0;
      end
      if (wr_en && word_addr == `IGR_OFF_CLR_PEND) begin
         pend_nxt = pend_nxt & ~pwdata[15:0];
      end
      if (wr_en && word_addr == `IGR_OFF_PRIM_END &&
          (shared_ack || !group_r[pwdata[3:0]])) begin
         end_clr[pwdata[3:0]] = 1'b1; // R7
      end
      if (wr_en && alias_on && !shared_ack && word_addr == `IGR_OFF_ALIAS_END &&
          group_r[pwdata[3:0]]) begin
         end_clr[pwdata[3:0]] = 1'b1; // R7 R8
      end
      pend_nxt = pend_nxt | (irq_in & ~irq_q_r);
      if (wr_en && word_addr == `IGR_OFF_SET_PEND) begin
         pend_nxt = pend_nxt | pwdata[15:0];
      end
      act_nxt = (act_r & ~end_clr) | ack_set;
   end

   // Bus slave: one wait cycle, read data and ack candidate captured in it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         ack_take_r <= 1'b0;
         ack_id_r <= 4'h0;
      end else begin
         pready <= acc_first;
         pslverr <= 1'b0;
         if (acc_first && !pwrite) begin
            prdata <= rd_data;
            ack_take_r <= ack_hit;
            ack_id_r <= best_id;
         end
         if (acc_done) begin
            ack_take_r <= 1'b0;
         end
      end
   end

   // Control and state registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dist_ctrl_r <= `IGR_RST_DIST_CTRL;
         cpu_ctrl_r <= `IGR_RST_CPU_CTRL;
         group_r <= GRP_RST; // R1 R11
         pend_r <= 16'h0000;
         act_r <= 16'h0000;
         irq_q_r <= 16'h0000;
         prim_split_r <= `IGR_RST_PRIM_SPLIT;
         alias_split_r <= `IGR_RST_ALIAS_SPLIT;
         for (k = 0; k < `IGR_NORMAL_REQUEST_N; k = k + 1) begin
            pri_r[k] <= 8'h00;
         end
         for (k = 0; k < `IGR_NLIST; k = k + 1) begin
            list_r[k] <= `IGR_RST_LIST;
         end
      end else begin
         irq_q_r <= irq_in;
         pend_r <= pend_nxt;
         act_r <= act_nxt;
         if (wr_en) begin
            case (word_addr)
               `IGR_OFF_DIST_CTRL: begin
                  dist_ctrl_r <= pwdata[1:0]; // R5
               end
               `IGR_OFF_CPU_CTRL: begin
                  cpu_ctrl_r <= pwdata[4:0]; // R6
               end
               `IGR_OFF_GROUP: begin
                  group_r <= pwdata[15:0]; // R2
               end
               `IGR_OFF_PRIM_SPLIT: begin
                  prim_split_r <= pwdata[2:0];
               end
               `IGR_OFF_ALIAS_SPLIT: begin
                  alias_split_r <= pwdata[2:0];
               end
               default: begin
                  if (word_addr[11:4] == `IGR_OFF_PRIO_BASE >> 4) begin
                     pri_r[{word_addr[3:2], 2'd0}] <= pwdata[7:0];
                     pri_r[{word_addr[3:2], 2'd1}] <= pwdata[15:8];
                     pri_r[{word_addr[3:2], 2'd2}] <= pwdata[23:16];
                     pri_r[{word_addr[3:2], 2'd3}] <= pwdata[31:24];
                  end else if (word_addr[11:4] == `IGR_OFF_LIST_BASE >> 4) begin
                     list_r[word_addr[3:2]] <= pwdata[11:0]; // R13
                  end
               end
            endcase
         end
      end
   end

   // Request outputs, re-evaluated every cycle; the processor does its own masking
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_request_n <= 1'b1;
         normal_request_n <= 1'b1;
         virtual_fast_request <= 1'b0;
         virtual_normal_request <= 1'b0;
      end else begin
         fast_request_n <= fast_nxt; // R17 R14
         normal_request_n <= normal_nxt; // R17 R15
         virtual_fast_request <= vfast_nxt;
         virtual_normal_request <= vnormal_nxt;
      end
   end

endmodule // igr_top
`default_nettype wire

/* File: sim/igr_chk.sv */
// Concurrent checks on the request outputs of the interrupt group routing block
`timescale 1ns/1ns
`default_nettype none
`include "igr_defs.vh"
module igr_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [15:0] irq_in,
   input wire logic fast_request_n,
   input wire logic normal_request_n,
   input wire logic virtual_fast_request,
   input wire logic virtual_normal_request
);
   logic [1:0] dist_r;
   logic [4:0] cpu_r;
   wire wr_done = psel && penable && pready && pwrite;
   wire [11:0] waddr = {paddr[11:2], 2'b00};
   // Shadow copies of the two control registers, updated at write completion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dist_r <= 2'h0;
         cpu_r <= 5'h00;
      end else if (wr_done && waddr == `IGR_OFF_DIST_CTRL) begin
         dist_r <= pwdata[1:0];
      end else if (wr_done && waddr == `IGR_OFF_CPU_CTRL) begin
         cpu_r <= pwdata[4:0];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_rq_idle; fast_request_n && normal_request_n; endsequence
   sequence s_all_idle; s_rq_idle ##0 (!virtual_fast_request && !virtual_normal_request); endsequence
   sequence s_cpu_off; wr_done && waddr == `IGR_OFF_CPU_CTRL && pwdata[1:0] == 2'h0; endsequence
   sequence s_dist_off; wr_done && waddr == `IGR_OFF_DIST_CTRL && pwdata[1:0] == 2'h0; endsequence
   property p_rst_idle; $rose(presetn) |-> s_all_idle ##1 s_all_idle; endproperty
   property p_fast_route; !fast_request_n |-> $past(cpu_r[`IGR_C_FAST]); endproperty
   property p_fast_g0; !fast_request_n |-> $past(cpu_r[`IGR_C_G0] && dist_r[`IGR_D_G0]); endproperty
   property p_norm_en; !normal_request_n |-> $past(cpu_r[`IGR_C_G0] || cpu_r[`IGR_C_G1]); endproperty
   property p_norm_dist; !normal_request_n |-> $past(dist_r != 2'h0); endproperty
   property p_one_line; !fast_request_n |-> normal_request_n; endproperty
   property p_cpu_off; s_cpu_off |-> ##2 s_rq_idle; endproperty
   property p_dist_off; s_dist_off |-> ##2 s_rq_idle; endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("request outputs not idle after reset");
   a_fast_route: assert property (p_fast_route) else $error("fast request without fast routing");
   a_fast_g0: assert property (p_fast_g0) else $error("fast request with group 0 disabled");
   a_norm_en: assert property (p_norm_en) else $error("normal request with groups disabled");
   a_norm_dist: assert property (p_norm_dist) else $error("normal request with forwarding off");
   a_one_line: assert property (p_one_line) else $error("fast and normal requests together");
   a_cpu_off: assert property (p_cpu_off) else $error("request stays after interface disable");
   a_dist_off: assert property (p_dist_off) else $error("request stays after forwarding disable");
endmodule // igr_chk
bind igr_top igr_chk igr_chk_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .irq_in(irq_in), .fast_request_n(fast_request_n), .normal_request_n(normal_request_n),
   .virtual_fast_request(virtual_fast_request), .virtual_normal_request(virtual_normal_request));
`default_nettype wire

/* File: sim/igr_cpu_model.sv */
// Processor core model that takes fast and normal interrupt requests
`timescale 1ns/1ns
`default_nettype none
module igr_cpu_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic fast_request_n,
   input wire logic normal_request_n,
   input wire logic ret,
   output logic in_fast,
   output logic in_norm
);
   // Return from exception clears both handler states
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_fast <= 1'b0;
         in_norm <= 1'b0;
      end else if (ret) begin
         in_fast <= 1'b0;
         in_norm <= 1'b0;
      end else begin
         if (!fast_request_n && !in_fast) in_fast <= 1'b1;
         if (!normal_request_n && !in_fast && !in_norm) in_norm <= 1'b1;
      end
   end
endmodule // igr_cpu_model
`default_nettype wire

/* File: sim/tb.sv */
// Testbench for the interrupt group routing block
`timescale 1ns/1ns
`default_nettype none
`include "igr_defs.vh"
module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic ret = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [15:0] irq_in = 16'h0;
   logic [31:0] prdata;
   logic pready, pslverr, fast_n, norm_n, vfast, vnorm, in_fast, in_norm;
   int error_cnt = 0;
   int samples_checked = 0;
   always #50 pclk = ~pclk;
   igr_top igr_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_in(irq_in),
      .fast_request_n(fast_n), .normal_request_n(norm_n), .virtual_fast_request(vfast),
      .virtual_normal_request(vnorm));
   igr_cpu_model igr_cpu_model_inst (.clk(pclk), .rst_n(presetn), .fast_request_n(fast_n),
      .normal_request_n(norm_n), .ret(ret), .in_fast(in_fast), .in_norm(in_norm));
   task print_verdict;
      begin
         $display("checked %0d mismatches %0d", samples_checked, error_cnt);
         if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      begin
         samples_checked++;
         if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      begin
         n = 0;
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         do begin
            @(posedge pclk);
            n++;
         end while (pready !== 1'b1 && n < 16);
         if (n >= 16) begin
            error_cnt++;
            print_verdict;
         end
         q = prdata;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] q;
      begin
         apb(1'b0, a, 32'h0, q);
         check(nm, q, exp);
      end
   endtask
   task settle(input int n);
      begin
         repeat (n) @(posedge pclk);
         @(negedge pclk);
      end
   endtask
   task irq_set(input logic [15:0] v);
      begin
         @(posedge pclk);
         irq_in <= v;
      end
   endtask
   task ret_pulse;
      begin
         @(posedge pclk);
         ret <= 1'b1;
         @(posedge pclk);
         ret <= 1'b0;
      end
   endtask
   task chk_req(input logic f, input logic n);
      begin
         check("fast_request_n", 32'(fast_n), 32'(f));
         check("normal_request_n", 32'(norm_n), 32'(n));
      end
   endtask
   task chk_virt(input logic f, input logic n);
      begin
         check("virtual_fast_request", 32'(vfast), 32'(f));
         check("virtual_normal_request", 32'(vnorm), 32'(n));
      end
   endtask
   task t_reset;
      begin
         rd(`IGR_OFF_GROUP, 32'h0, "group");
         rd(`IGR_OFF_DIST_CTRL, 32'h0, "dist ctrl");
         rd(`IGR_OFF_CPU_CTRL, 32'h0, "cpu ctrl");
         settle(1);
         chk_req(1'b1, 1'b1);
         $display("t_reset done");
      end
   endtask
   task t_fast;
      begin
         wr(`IGR_OFF_DIST_CTRL, 32'h3);
         wr(`IGR_OFF_CPU_CTRL, 32'hB);
         irq_set(16'h0020);
         settle(3);
         chk_req(1'b0, 1'b1);
         rd(`IGR_OFF_PRIM_ACK, 32'h5, "primary ack");
         check("taken fast", 32'(in_fast), 32'h1);
         wr(`IGR_OFF_PRIM_END, 32'h5);
         settle(2);
         chk_req(1'b1, 1'b1);
         ret_pulse;
         $display("t_fast done");
      end
   endtask
   task t_group1;
      begin
         wr(`IGR_OFF_GROUP, 32'h40);
         rd(`IGR_OFF_GROUP, 32'h40, "group");
         irq_set(16'h0040);
         settle(3);
         chk_req(1'b1, 1'b0);
         rd(`IGR_OFF_PRIM_ACK, 32'(`IGR_SPURIOUS), "primary ack");
         rd(`IGR_OFF_ALIAS_ACK, 32'h6, "alias ack");
         check("taken normal", 32'(in_norm), 32'h1);
         wr(`IGR_OFF_ALIAS_END, 32'h6);
         settle(2);
         chk_req(1'b1, 1'b1);
         ret_pulse;
         $display("t_group1 done");
      end
   endtask
   task t_enables;
      logic [8:0] tbl [7] = '{9'h1AD, 9'h1AB, 9'h18E, 9'h12F, 9'h18B, 9'h086, 9'h00F};
      begin
         wr(`IGR_OFF_GROUP, 32'h0);
         wr(`IGR_OFF_SET_PEND, 32'h20);
         for (int i = 0; i < 7; i++) begin
            wr(`IGR_OFF_DIST_CTRL, 32'(tbl[i][8:7]));
            wr(`IGR_OFF_CPU_CTRL, 32'(tbl[i][6:2]));
            settle(2);
            chk_req(tbl[i][1], tbl[i][0]);
         end
         wr(`IGR_OFF_CPU_CTRL, 32'h0);
         wr(`IGR_OFF_CLR_PEND, 32'h20);
         $display("t_enables done");
      end
   endtask
   task t_split;
      begin
         wr(`IGR_OFF_GROUP, 32'h200);
         wr(`IGR_OFF_PRIO_BASE + 12'h008, 32'h2040);
         wr(`IGR_OFF_DIST_CTRL, 32'h3);
         wr(`IGR_OFF_CPU_CTRL, 32'h3);
         wr(`IGR_OFF_SET_PEND, 32'h100);
         rd(`IGR_OFF_PRIM_ACK, 32'h8, "primary ack");
         wr(`IGR_OFF_ALIAS_SPLIT, 32'h7);
         wr(`IGR_OFF_SET_PEND, 32'h200);
         settle(2);
         chk_req(1'b1, 1'b1);
         wr(`IGR_OFF_CPU_CTRL, 32'h17);
         settle(2);
         chk_req(1'b1, 1'b0);
         rd(`IGR_OFF_PRIM_ACK, 32'h9, "shared ack");
         wr(`IGR_OFF_PRIM_END, 32'h9);
         wr(`IGR_OFF_PRIM_END, 32'h8);
         rd(`IGR_OFF_ACTIVE, 32'h0, "active");
         wr(`IGR_OFF_CPU_CTRL, 32'h0);
         wr(`IGR_OFF_ALIAS_SPLIT, 32'h3);
         ret_pulse;
         $display("t_split done");
      end
   endtask
   task t_virtual;
      begin
         wr(`IGR_OFF_CPU_CTRL, 32'hB);
         wr(`IGR_OFF_LIST_BASE, 32'h807);
         settle(2);
         chk_virt(1'b1, 1'b0);
         wr(`IGR_OFF_LIST_BASE, 32'hC07);
         settle(2);
         chk_virt(1'b0, 1'b1);
         wr(`IGR_OFF_LIST_BASE, 32'h0);
         settle(2);
         chk_virt(1'b0, 1'b0);
         $display("t_virtual done");
      end
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_fast;
      t_group1;
      t_enables;
      t_split;
      t_virtual;
      print_verdict;
   end
endmodule // tb
`default_nettype wire
